// ==== core/rx_port_page_pkg.sv ====
// constants for the receive-port paging and embedded-type block
package rx_port_page_pkg;
    localparam logic [7:0] ADDR_PORT_CAP = 8'h4a;
    localparam logic [7:0] ADDR_EMBED_TYPE = 8'h4b;
    localparam logic [7:0] ADDR_PAGE_SEL = 8'h4c;
    localparam logic [7:0] ADDR_PAGED_LO = 8'h4d;
    localparam logic [7:0] ADDR_PAGED_HI = 8'h7f;
    localparam logic [7:0] ADDR_PAGED2_LO = 8'hd0;
    localparam logic [7:0] ADDR_PAGED2_HI = 8'hdf;
    localparam int NUM_PORTS = 2;
    localparam int NUM_SRC = 3;
    localparam logic [1:0] SRC_LOCAL = 2'h0;
    localparam logic [1:0] SRC_BC_PORT0 = 2'h1;
    localparam logic [1:0] SRC_BC_PORT1 = 2'h2;
    localparam int SEL_READ_BIT = 4;
    localparam int SEL_PHYS_BIT = 6;
    localparam int EMB_ENABLE_HI = 7;
    localparam int EMB_ENABLE_LO = 6;
    localparam int EMB_VALUE_HI = 5;
    localparam int EMB_VALUE_LO = 0;
    localparam logic [7:0] PORT_CAP_RST = 8'h00;
    localparam logic [7:0] EMBED_TYPE_RST = 8'h12;
    localparam logic [NUM_SRC-1:0] READ_SEL_RST = 3'h4;
    localparam logic [2*NUM_SRC-1:0] WRITE_EN_RST = 6'h24;
    localparam logic [1:0] EMB_COUNT_RST = 2'h0;
endpackage : rx_port_page_pkg

// ==== core/rx_port_page_select_embed_dtype.sv ====
// receive-port register paging and raw-mode embedded data type relabelling
//
// Operation
// - relabel only when port is in raw mode
// - enable 00 forwards every packet unchanged
// - enable 1..3 relabels first N long packets
// - relabelled packets carry programmed 6-bit type
// - paged addresses route through port select
// - port cap and embed type reads return selected port's block, other paged reads zero
// - read select defaults to source port number
// - writes update every enabled port block
// - write enables default per access source
// - physical port bit shows carrying port
// - each access source keeps its own paging
`timescale 1ns/1ps
module rx_port_page_select_embed_dtype
    import rx_port_page_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic [1:0] acc_source_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic [1:0] port_raw_mode_i,
    input wire logic [1:0] pkt_frame_start_i,
    input wire logic [1:0] pkt_valid_i,
    input wire logic [1:0] pkt_long_i,
    input wire logic [11:0] pkt_dtype_i,
    output logic [1:0] pkt_valid_o,
    output logic [1:0] pkt_embedded_o,
    output logic [11:0] pkt_dtype_o
);
    logic [NUM_PORTS-1:0][7:0] cap_r, cap_nxt;
    logic [NUM_PORTS-1:0][7:0] emb_r, emb_nxt;
    logic [NUM_SRC-1:0] rsel_r, rsel_nxt;
    logic [NUM_SRC-1:0][1:0] wen_r, wen_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic [NUM_PORTS-1:0][1:0] cnt_r, cnt_nxt;
    logic [1:0] pv_r, pv_nxt;
    logic [1:0] pe_r, pe_nxt;
    logic [NUM_PORTS-1:0][5:0] pd_r, pd_nxt;
    logic [1:0] src;
    logic rport;
    logic [7:0] emb_sel;

    function automatic logic is_paged(input logic [7:0] a);
        is_paged = (a == ADDR_PORT_CAP) || (a == ADDR_EMBED_TYPE)
            || ((a >= ADDR_PAGED_LO) && (a <= ADDR_PAGED_HI))
            || ((a >= ADDR_PAGED2_LO) && (a <= ADDR_PAGED2_HI));
    endfunction : is_paged

    // unknown source codes fall back to the local interface
    assign src = (acc_source_i > SRC_BC_PORT1) ? SRC_LOCAL : acc_source_i;
    assign rport = rsel_r[src];
    assign emb_sel = emb_r[rport];

    // register file next state
    always_comb
    begin
        cap_nxt = cap_r;
        emb_nxt = emb_r;
        rsel_nxt = rsel_r;
        wen_nxt = wen_r;
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = 1'b0;
        if (acc_valid_i && acc_write_i)
        begin
            if (acc_addr_i == ADDR_PAGE_SEL)
            begin
                rsel_nxt[src] = acc_wdata_i[SEL_READ_BIT];
                wen_nxt[src] = acc_wdata_i[1:0];
            end
            else if (is_paged(acc_addr_i))
            begin
                for (int p = 0; p < NUM_PORTS; p++)
                begin
                    if (wen_r[src][p])
                    begin
                        if (acc_addr_i == ADDR_PORT_CAP)
                            cap_nxt[p] = acc_wdata_i;
                        if (acc_addr_i == ADDR_EMBED_TYPE)
                            emb_nxt[p] = acc_wdata_i;
                    end
                end
            end
        end
        else if (acc_valid_i)
        begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = 8'h00;
            if (acc_addr_i == ADDR_PAGE_SEL)
            begin
                rd_data_nxt[SEL_PHYS_BIT] = (src == SRC_BC_PORT1);
                rd_data_nxt[SEL_READ_BIT] = rsel_r[src];
                rd_data_nxt[1:0] = wen_r[src];
            end
            else if (acc_addr_i == ADDR_PORT_CAP)
                rd_data_nxt = cap_r[rport];
            else if (acc_addr_i == ADDR_EMBED_TYPE)
                rd_data_nxt = emb_sel;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            cap_r <= {NUM_PORTS{PORT_CAP_RST}};
            emb_r <= {NUM_PORTS{EMBED_TYPE_RST}};
            rsel_r <= READ_SEL_RST;
            wen_r <= WRITE_EN_RST;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            cap_r <= cap_nxt;
            emb_r <= emb_nxt;
            rsel_r <= rsel_nxt;
            wen_r <= wen_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // packet relabelling next state
    always_comb
    begin
        cnt_nxt = cnt_r;
        pv_nxt = pkt_valid_i;
        pe_nxt = 2'h0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            pd_nxt[p] = pkt_dtype_i[6*p +: 6];
            if (pkt_frame_start_i[p])
                cnt_nxt[p] = EMB_COUNT_RST;
            else if (pkt_valid_i[p] && pkt_long_i[p] && port_raw_mode_i[p])
            begin
                if (cnt_r[p] < emb_r[p][EMB_ENABLE_HI:EMB_ENABLE_LO])
                begin
                    pd_nxt[p] = emb_r[p][EMB_VALUE_HI:EMB_VALUE_LO];
                    pe_nxt[p] = 1'b1;
                    cnt_nxt[p] = cnt_r[p] + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            cnt_r <= {NUM_PORTS{EMB_COUNT_RST}};
            pv_r <= 2'h0;
            pe_r <= 2'h0;
            pd_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            pv_r <= pv_nxt;
            pe_r <= pe_nxt;
            pd_r <= pd_nxt;
        end
    end

    assign rd_data_o = rd_data_r;
    assign rd_valid_o = rd_valid_r;
    assign pkt_valid_o = pv_r;
    assign pkt_embedded_o = pe_r;
    assign pkt_dtype_o = {pd_r[1], pd_r[0]};

    property p_read_page;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && !acc_write_i && acc_addr_i == ADDR_EMBED_TYPE)
            |=> (rd_valid_o && rd_data_o == $past(emb_sel));
    endproperty
    a_read_page: assert property (p_read_page) else $error("paged read wrong port");

    property p_read_cap;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && !acc_write_i && acc_addr_i == ADDR_PORT_CAP)
            |=> (rd_valid_o && rd_data_o == $past(cap_r[rport]));
    endproperty
    a_read_cap: assert property (p_read_cap) else $error("paged read not routed");

    property p_read_direct;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && !acc_write_i && !is_paged(acc_addr_i) && acc_addr_i != ADDR_PAGE_SEL)
            |=> (rd_valid_o && rd_data_o == 8'h00);
    endproperty
    a_read_direct: assert property (p_read_direct) else $error("direct read not zero");

    property p_write_on;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && acc_write_i && acc_addr_i == ADDR_EMBED_TYPE && wen_r[src][0])
            |=> emb_r[0] == $past(acc_wdata_i);
    endproperty
    a_write_on: assert property (p_write_on) else $error("enabled port not written");

    property p_write_off;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && acc_write_i && !wen_r[src][1]) |=> $stable(emb_r[1]);
    endproperty
    a_write_off: assert property (p_write_off) else $error("disabled port written");

    property p_phys_bit;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && !acc_write_i && acc_addr_i == ADDR_PAGE_SEL)
            |=> rd_data_o[SEL_PHYS_BIT] == ($past(acc_source_i) == SRC_BC_PORT1);
    endproperty
    a_phys_bit: assert property (p_phys_bit) else $error("physical port bit wrong");

    property p_sel_reserved;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && !acc_write_i && acc_addr_i == ADDR_PAGE_SEL)
            |=> (rd_data_o[7] == 1'b0 && rd_data_o[5] == 1'b0 && rd_data_o[3:2] == 2'h0);
    endproperty
    a_sel_reserved: assert property (p_sel_reserved) else $error("reserved bits set");

    property p_own_copy;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (acc_valid_i && acc_write_i && acc_source_i == SRC_LOCAL)
            |=> ($stable(rsel_r[2:1]) && $stable(wen_r[2]) && $stable(wen_r[1]));
    endproperty
    a_own_copy: assert property (p_own_copy) else $error("other source paging changed");

    property p_not_raw;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (pkt_valid_i[0] && !port_raw_mode_i[0])
            |=> (!pkt_embedded_o[0] && pkt_dtype_o[5:0] == $past(pkt_dtype_i[5:0]));
    endproperty
    a_not_raw: assert property (p_not_raw) else $error("relabel outside raw mode");

    property p_disabled;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (pkt_valid_i[1] && emb_r[1][EMB_ENABLE_HI:EMB_ENABLE_LO] == 2'h0)
            |=> (!pkt_embedded_o[1] && pkt_dtype_o[11:6] == $past(pkt_dtype_i[11:6]));
    endproperty
    a_disabled: assert property (p_disabled) else $error("relabel while disabled");

    property p_relabel;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (pkt_valid_i[0] && pkt_long_i[0] && port_raw_mode_i[0] && !pkt_frame_start_i[0]
            && cnt_r[0] < emb_r[0][EMB_ENABLE_HI:EMB_ENABLE_LO])
            |=> (pkt_embedded_o[0] && pkt_dtype_o[5:0] == $past(emb_r[0][5:0])
                && cnt_r[0] == $past(cnt_r[0]) + 2'h1);
    endproperty
    a_relabel: assert property (p_relabel) else $error("first packets not relabelled");
endmodule : rx_port_page_select_embed_dtype

// ==== testbench/reg_host_model.sv ====
// register host model for local and back-channel byte accesses
`timescale 1ns/1ps
module reg_host_model (
    input wire logic core_clk_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [7:0] acc_addr_o,
    output logic [7:0] acc_wdata_o,
    output logic [1:0] acc_source_o
);
    initial
    begin
        {acc_valid_o, acc_write_o, acc_addr_o, acc_wdata_o, acc_source_o} = 19'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] s, output logic [7:0] q);
        @(posedge core_clk_i);
        #1;
        {acc_valid_o, acc_write_o, acc_addr_o, acc_wdata_o, acc_source_o} = {1'b1, w, a, d, s};
        @(posedge core_clk_i);
        #1;
        // released lines show the inverse so stale values are never taken as fresh
        {acc_valid_o, acc_addr_o, acc_wdata_o} = {1'b0, ~a, ~d};
        q = rd_valid_i ? rd_data_i : 8'hxx;
    endtask : xfer
endmodule : reg_host_model

// ==== testbench/tb.sv ====
// self-checking bench for receive-port paging and embedded-type relabelling
`timescale 1ns/1ps
module tb;
    import rx_port_page_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic acc_valid_i, acc_write_i, rd_valid_o;
    logic [7:0] acc_addr_i, acc_wdata_i, rd_data_o, q, v0, v1;
    logic [1:0] acc_source_i, pkt_valid_o, pkt_embedded_o;
    logic [1:0] port_raw_mode_i = 2'b01;
    logic [1:0] pkt_frame_start_i = 2'b00, pkt_valid_i = 2'b00, pkt_long_i = 2'b00;
    logic [11:0] pkt_dtype_i = 12'h000, pkt_dtype_o;
    logic [7:0] sel_m, d_m;
    logic [1:0] s_m;
    logic [7:0] cap_m [NUM_PORTS];
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 core_clk_i = ~core_clk_i;
    rx_port_page_select_embed_dtype u_rx_port_page_select_embed_dtype (
        .core_clk_i, .reset_n_i, .acc_valid_i, .acc_write_i, .acc_addr_i, .acc_wdata_i,
        .acc_source_i, .rd_data_o, .rd_valid_o, .port_raw_mode_i, .pkt_frame_start_i,
        .pkt_valid_i, .pkt_long_i, .pkt_dtype_i, .pkt_valid_o, .pkt_embedded_o, .pkt_dtype_o);
    reg_host_model u_reg_host_model (.core_clk_i, .rd_valid_i(rd_valid_o),
        .rd_data_i(rd_data_o), .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i),
        .acc_addr_o(acc_addr_i), .acc_wdata_o(acc_wdata_i), .acc_source_o(acc_source_i));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] s);
        u_reg_host_model.xfer(1'b1, a, d, s, q);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [1:0] s, input logic [7:0] e);
        u_reg_host_model.xfer(1'b0, a, 8'h00, s, q);
        chk({8'h00, q}, {8'h00, e});
    endtask : rchk
    function automatic logic [13:0] exp_pkt(input int i, input logic [1:0] lg,
        input logic [11:0] dt);
        logic [1:0] emb;
        emb = port_raw_mode_i & lg & {2{i < v0[7:6]}};
        return {emb, emb[1] ? v0[5:0] : dt[11:6], emb[0] ? v0[5:0] : dt[5:0]};
    endfunction : exp_pkt
    task automatic pkt(input logic [1:0] fs, input logic [1:0] v, input logic [1:0] lg,
        input int i);
        logic [11:0] dt;
        dt = 12'($urandom);
        @(posedge core_clk_i);
        #1;
        {pkt_frame_start_i, pkt_valid_i, pkt_long_i, pkt_dtype_i} = {fs, v, lg, dt};
        @(posedge core_clk_i);
        #1;
        {pkt_frame_start_i, pkt_valid_i, pkt_long_i, pkt_dtype_i} = {6'h00, ~dt};
        if (v != 2'b00)
            chk({pkt_valid_o, pkt_embedded_o, pkt_dtype_o}, {v, exp_pkt(i, lg, dt)});
    endtask : pkt
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    initial
    begin
        void'($urandom(15763));
        repeat (16) @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b1;
        rchk(ADDR_EMBED_TYPE, SRC_LOCAL, EMBED_TYPE_RST);
        rchk(ADDR_PAGE_SEL, SRC_LOCAL, 8'h00);
        rchk(ADDR_PAGE_SEL, SRC_BC_PORT0, 8'h01);
        rchk(ADDR_PAGE_SEL, SRC_BC_PORT1, 8'h52);
        rchk(ADDR_PORT_CAP, SRC_LOCAL, PORT_CAP_RST);
        v0 = 8'($urandom);
        v1 = 8'($urandom);
        wr(ADDR_PAGE_SEL, 8'hff, SRC_LOCAL);
        rchk(ADDR_PAGE_SEL, SRC_LOCAL, 8'h13);
        wr(ADDR_EMBED_TYPE, v0, SRC_LOCAL);
        wr(ADDR_PAGE_SEL, 8'h12, SRC_LOCAL);
        wr(ADDR_EMBED_TYPE, v1, SRC_LOCAL);
        rchk(ADDR_EMBED_TYPE, SRC_LOCAL, v1);
        wr(ADDR_PAGE_SEL, 8'h00, SRC_LOCAL);
        wr(ADDR_EMBED_TYPE, 8'h00, SRC_LOCAL);
        rchk(ADDR_EMBED_TYPE, SRC_LOCAL, v0);
        rchk(ADDR_PAGE_SEL, SRC_BC_PORT0, 8'h01);
        rchk(ADDR_EMBED_TYPE, SRC_BC_PORT1, v1);
        wr(ADDR_EMBED_TYPE, 8'h2a, SRC_BC_PORT0);
        rchk(ADDR_EMBED_TYPE, SRC_LOCAL, 8'h2a);
        rchk(ADDR_EMBED_TYPE, SRC_BC_PORT1, v1);
        wr(8'h44, 8'h5a, SRC_LOCAL);
        rchk(8'h44, SRC_LOCAL, 8'h00);
        rchk(ADDR_PAGED_LO, SRC_LOCAL, 8'h00);
        wr(ADDR_PAGE_SEL, 8'h03, SRC_LOCAL);
        for (int en = 0; en < 4; en++)
        begin
            v0 = {en[1:0], 6'($urandom)};
            wr(ADDR_EMBED_TYPE, v0, SRC_LOCAL);
            port_raw_mode_i = {en[0], ~en[0]};
            pkt(2'b11, 2'b00, 2'b00, 0);
            for (int i = 0; i < 5; i++)
                pkt(2'b00, 2'b11, 2'b11, i);
        end
        port_raw_mode_i = 2'b11;
        v0 = {2'h2, 6'($urandom)};
        wr(ADDR_EMBED_TYPE, v0, SRC_LOCAL);
        pkt(2'b11, 2'b11, 2'b11, 2);
        pkt(2'b00, 2'b11, 2'b00, 0);
        for (int i = 0; i < 3; i++)
            pkt(2'b00, 2'b11, 2'b11, i);
        @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b1;
        rchk(ADDR_PAGE_SEL, SRC_LOCAL, 8'h00);
        rchk(ADDR_EMBED_TYPE, SRC_BC_PORT1, EMBED_TYPE_RST);
        cap_m = '{PORT_CAP_RST, PORT_CAP_RST};
        for (int k = 0; k < 40; k++)
        begin
            s_m = 2'($urandom_range(3));
            sel_m = 8'($urandom) & 8'h13;
            d_m = 8'($urandom);
            wr(ADDR_PAGE_SEL, sel_m, s_m);
            rchk(ADDR_PAGE_SEL, s_m, sel_m | ((s_m == SRC_BC_PORT1) ? 8'h40 : 8'h00));
            wr(ADDR_PORT_CAP, d_m, s_m);
            for (int p = 0; p < NUM_PORTS; p++)
                if (sel_m[p])
                    cap_m[p] = d_m;
            rchk(ADDR_PORT_CAP, s_m, cap_m[sel_m[4]]);
        end
        give_verdict();
    end
endmodule : tb
